// [hw/pft_pkg.sv]
// Package for the highway frame timing block: register map, reset values, field layouts.
// Assumes a 32-bit classic Wishbone bus with data in the low byte of each word.
package pft_pkg;

    // Register byte offsets
    localparam logic [7:0] PFT_OFS_MODE = 8'h00;
    localparam logic [7:0] PFT_OFS_LEN = 8'h04;
    localparam logic [7:0] PFT_OFS_DOFF = 8'h08;
    localparam logic [7:0] PFT_OFS_UOFF = 8'h0c;
    localparam logic [7:0] PFT_OFS_SHIFT = 8'h10;
    localparam logic [7:0] PFT_OFS_STATUS = 8'h14;

    // Values after reset
    localparam logic [7:0] PFT_RST_MODE = 8'h00;
    localparam logic [7:0] PFT_RST_LEN = 8'hff;
    localparam logic [7:0] PFT_RST_DOFF = 8'h00;
    localparam logic [7:0] PFT_RST_UOFF = 8'h00;
    localparam logic [7:0] PFT_RST_SHIFT = 8'h00;

    // Status register field position
    localparam int unsigned PFT_STS_SYNC_BIT = 0;

    typedef enum logic [1:0] {
        PFT_MODE_QUAD = 2'h0,
        PFT_MODE_DUAL = 2'h1,
        PFT_MODE_SINGLE = 2'h2,
        PFT_MODE_DUP = 2'h3
    } pft_mode_t;

    // highway_mode_reg layout, bit 7 down to bit 0
    typedef struct packed {
        pft_mode_t mode;
        logic pcr;
        logic sync_sample_edge_sel;
        logic alt_input_sel_hi;
        logic alt_input_sel_lo;
        logic [1:0] spare;
    } pft_mode_reg_t;

    // clock_shift_reg layout, bit 7 down to bit 0
    typedef struct packed {
        logic downstream_clock_shift;
        logic [1:0] ofd_lo;
        logic downstream_edge_sel;
        logic alt_shift_option;
        logic [1:0] ofu_lo;
        logic upstream_edge_sel;
    } pft_shift_reg_t;

endpackage : pft_pkg

// [hw/pft_sync.sv]
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes inputs are levels; only the second stage may be read.
`timescale 1ns/1ps
`default_nettype none

module pft_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Levels
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end

endmodule : pft_sync

`default_nettype wire

// [hw/pft_frame_timing.sv]
// Frame timing and port mapping of a four-line TDM highway, with a Wishbone register slave.
// Assumes highway_bit_clock_i is far slower than clk_i (at least four clk_i periods per half cycle).
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Detected frame sync clears bit counter
// - Counter wraps at programmed frame length
// - Sync period check shown in status
// - Sync sampled on edge chosen by select
// - Sampled low-to-high sync marks bit zero
// - Transmit launch edge chosen by upstream select
// - Receive capture edge chosen by downstream select
// - Separate whole-bit offsets per direction
// - Logical transmit ports fixed to physical lines
// - Modes one, three: select bits choose lines
// - Mode two: high select chooses line
// - Modes one to three: select bits drive tristate pins one, three
// - Per-mode driving, floating, duplicating transmit lines
// - Tristate control low while line valid, except lines one, three in modes one to three
// - Mode field gives four, two, one, two ports
module pft_frame_timing (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Highway pins
    input wire logic highway_bit_clock_i,
    input wire logic frame_sync_in_i,
    input wire logic [3:0] rxd_i,
    output logic [3:0] txd_o,
    output logic [3:0] txd_oe_o,
    output logic [3:0] transmit_tristate_ctl_n_o,
    // Logical transmit side
    input wire logic [3:0] tx_data_i,
    input wire logic [3:0] tx_valid_i,
    output logic tx_take_o,
    output logic [9:0] up_pos_o,
    // Logical receive side
    output logic [3:0] rx_data_o,
    output logic rx_stb_o,
    output logic [9:0] dn_pos_o
);

    pft_pkg::pft_mode_reg_t mode_q;
    pft_pkg::pft_shift_reg_t shift_q;
    logic [7:0] len_q;
    logic [7:0] doff_q;
    logic [7:0] uoff_q;
    logic sync_ok_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [7:0] rd_byte;
    logic wb_req;

    logic [5:0] pins_s;
    logic bclk_q;
    logic rise;
    logic fall;
    logic fs_samp_q;
    logic fs_edge;
    logic sync_hit;
    logic sync_pend_q;
    logic phase_q;
    logic tick;
    logic [9:0] cnt_q;
    logic [9:0] last_bit;
    logic [9:0] dn_pos;
    logic [9:0] up_pos;
    logic [9:0] up_pos_q;
    logic [9:0] dn_pos_q;
    logic rx_edge;
    logic launch;
    logic [3:0] rx_log;
    logic [3:0] rx_data_q;
    logic rx_stb_q;
    logic [3:0] txd_d;
    logic [3:0] oe_d;
    logic [3:0] tsc_d;
    logic [3:0] txd_q;
    logic [3:0] oe_q;
    logic [3:0] tsc_q;
    logic tx_take_q;

    // Register slave: one wait state, every address answered
    assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= pft_pkg::PFT_RST_MODE;
            len_q <= pft_pkg::PFT_RST_LEN;
            doff_q <= pft_pkg::PFT_RST_DOFF;
            uoff_q <= pft_pkg::PFT_RST_UOFF;
            shift_q <= pft_pkg::PFT_RST_SHIFT;
        end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                pft_pkg::PFT_OFS_MODE: mode_q <= wb_dat_i[7:0];
                pft_pkg::PFT_OFS_LEN: len_q <= wb_dat_i[7:0];
                pft_pkg::PFT_OFS_DOFF: doff_q <= wb_dat_i[7:0];
                pft_pkg::PFT_OFS_UOFF: uoff_q <= wb_dat_i[7:0];
                pft_pkg::PFT_OFS_SHIFT: shift_q <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        unique case (wb_adr_i)
            pft_pkg::PFT_OFS_MODE: rd_byte = mode_q;
            pft_pkg::PFT_OFS_LEN: rd_byte = len_q;
            pft_pkg::PFT_OFS_DOFF: rd_byte = doff_q;
            pft_pkg::PFT_OFS_UOFF: rd_byte = uoff_q;
            pft_pkg::PFT_OFS_SHIFT: rd_byte = shift_q;
            pft_pkg::PFT_OFS_STATUS: rd_byte[pft_pkg::PFT_STS_SYNC_BIT] = sync_ok_q;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0000_0000;
        end else if (wb_req) begin
            dat_q <= {24'h00_0000, rd_byte};
        end
    end

    // Pin inputs cross into clk_i before anything looks at them
    pft_sync #(.WIDTH(6)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({highway_bit_clock_i, frame_sync_in_i, rxd_i}),
        .q_o(pins_s)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bclk_q <= 1'b0;
        end else begin
            bclk_q <= pins_s[5];
        end
    end

    assign rise = pins_s[5] & ~bclk_q;
    assign fall = ~pins_s[5] & bclk_q;

    // Frame sync sampling and first-bit detection
    assign fs_edge = mode_q.sync_sample_edge_sel ? rise : fall;
    assign sync_hit = fs_edge & pins_s[4] & ~fs_samp_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fs_samp_q <= 1'b0;
        end else if (fs_edge) begin
            fs_samp_q <= pins_s[4];
        end
    end

    // New sync wins over consumption in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_pend_q <= 1'b0;
        end else if (sync_hit) begin
            sync_pend_q <= 1'b1;
        end else if (tick) begin
            sync_pend_q <= 1'b0;
        end
    end

    // Double clock rate: one bit per two rising edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= 1'b0;
        end else if (rise) begin
            phase_q <= ~phase_q;
        end
    end

    assign tick = rise & (~mode_q.pcr | phase_q);

    // Last bit number from the encoded length field
    always_comb begin
        unique case (mode_q.mode)
            pft_pkg::PFT_MODE_QUAD: last_bit = {2'h0, len_q};
            pft_pkg::PFT_MODE_DUAL,
            pft_pkg::PFT_MODE_DUP: last_bit = {1'b0, len_q, 1'b1};
            pft_pkg::PFT_MODE_SINGLE: last_bit = {len_q, 2'h3};
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 10'h000;
        end else if (tick) begin
            if (sync_pend_q) begin
                cnt_q <= 10'h000;
            end else if (cnt_q == last_bit) begin
                cnt_q <= 10'h000;
            end else begin
                cnt_q <= cnt_q + 10'h001;
            end
        end
    end

    // A wrap with no sync pulse means lost synchronisation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_ok_q <= 1'b0;
        end else if (tick && sync_pend_q) begin
            sync_ok_q <= (cnt_q == last_bit);
        end else if (tick && cnt_q == last_bit) begin
            sync_ok_q <= 1'b0;
        end
    end

    // Offset addition modulo frame length; offset must stay below the length
    function automatic logic [9:0] wrap_pos(input logic [9:0] cnt, input logic [9:0] off, input logic [9:0] last);
        logic [10:0] sum;
        sum = {1'b0, cnt} + {1'b0, off};
        if (sum > {1'b0, last}) begin
            sum = sum - ({1'b0, last} + 11'h001);
        end
        return sum[9:0];
    endfunction : wrap_pos

    assign dn_pos = wrap_pos(cnt_q, {doff_q, shift_q.ofd_lo}, last_bit);
    assign up_pos = wrap_pos(cnt_q, {uoff_q, shift_q.ofu_lo}, last_bit);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            up_pos_q <= 10'h000;
        end else begin
            up_pos_q <= up_pos;
        end
    end

    // Receive line selection
    always_comb begin
        rx_log = 4'h0;
        unique case (mode_q.mode)
            pft_pkg::PFT_MODE_QUAD: rx_log = pins_s[3:0];
            pft_pkg::PFT_MODE_DUAL,
            pft_pkg::PFT_MODE_DUP: begin
                rx_log[0] = mode_q.alt_input_sel_lo ? pins_s[0] : pins_s[1];
                rx_log[1] = mode_q.alt_input_sel_hi ? pins_s[2] : pins_s[3];
            end
            pft_pkg::PFT_MODE_SINGLE: rx_log[0] = mode_q.alt_input_sel_hi ? pins_s[2] : pins_s[3];
        endcase
    end

    assign rx_edge = shift_q.downstream_edge_sel ? rise : fall;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_stb_q <= 1'b0;
            rx_data_q <= 4'h0;
            dn_pos_q <= 10'h000;
        end else begin
            rx_stb_q <= rx_edge;
            if (rx_edge) begin
                rx_data_q <= rx_log;
                dn_pos_q <= dn_pos;
            end
        end
    end

    // Transmit line mapping; undriven lines float, control inactive except select bits on lines one and three in modes one to three
    always_comb begin
        txd_d = 4'h0;
        oe_d = 4'h0;
        tsc_d = 4'hf;
        unique case (mode_q.mode)
            pft_pkg::PFT_MODE_QUAD: begin
                txd_d = tx_data_i;
                oe_d = tx_valid_i;
                tsc_d = ~tx_valid_i;
            end
            pft_pkg::PFT_MODE_DUAL: begin
                txd_d = {1'b0, tx_data_i[1], 1'b0, tx_data_i[0]};
                oe_d = {1'b0, tx_valid_i[1], 1'b0, tx_valid_i[0]};
                tsc_d = {mode_q.alt_input_sel_hi, ~tx_valid_i[1], mode_q.alt_input_sel_lo, ~tx_valid_i[0]};
            end
            pft_pkg::PFT_MODE_SINGLE: begin
                txd_d = {3'h0, tx_data_i[0]};
                oe_d = {3'h0, tx_valid_i[0]};
                tsc_d = {mode_q.alt_input_sel_hi, 1'b1, mode_q.alt_input_sel_lo, ~tx_valid_i[0]};
            end
            pft_pkg::PFT_MODE_DUP: begin
                txd_d = {tx_data_i[1], tx_data_i[1], tx_data_i[0], tx_data_i[0]};
                oe_d = {tx_valid_i[1], tx_valid_i[1], tx_valid_i[0], tx_valid_i[0]};
                tsc_d = {mode_q.alt_input_sel_hi, ~tx_valid_i[1], mode_q.alt_input_sel_lo, ~tx_valid_i[0]};
            end
        endcase
    end

    assign launch = shift_q.upstream_edge_sel ? rise : fall;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txd_q <= 4'h0;
            oe_q <= 4'h0;
            tsc_q <= 4'hf;
            tx_take_q <= 1'b0;
        end else begin
            tx_take_q <= launch;
            if (launch) begin
                txd_q <= txd_d;
                oe_q <= oe_d;
                tsc_q <= tsc_d;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign txd_o = txd_q;
    assign txd_oe_o = oe_q;
    assign transmit_tristate_ctl_n_o = tsc_q;
    assign tx_take_o = tx_take_q;
    assign up_pos_o = up_pos_q;
    assign rx_data_o = rx_data_q;
    assign rx_stb_o = rx_stb_q;
    assign dn_pos_o = dn_pos_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_ack_answer: assert property (wb_req |=> ack_q ##1 !ack_q)
        else $error("bus ack not a single pulse one cycle after request");
    chk_sync_clears: assert property (tick && sync_pend_q |=> cnt_q == 10'h000)
        else $error("counter not cleared by frame sync");
    chk_counter_wrap: assert property (tick && !sync_pend_q && cnt_q == last_bit |=> cnt_q == 10'h000)
        else $error("counter did not wrap at frame length");
    chk_sync_status: assert property (tick && sync_pend_q |=> sync_ok_q == $past(cnt_q == last_bit))
        else $error("sync status does not match period check");
    chk_sync_sample: assert property (fs_edge && pins_s[4] && !fs_samp_q && !tick |=> sync_pend_q)
        else $error("sampled sync rise not registered");
    chk_tsc_valid: assert property (transmit_tristate_ctl_n_o[0] != txd_oe_o[0])
        else $error("tristate control zero disagrees with line zero drive");
    chk_float_lines: assert property (launch && mode_q.mode == pft_pkg::PFT_MODE_DUAL
        |=> !txd_oe_o[1] && !txd_oe_o[3])
        else $error("floating lines driven in dual mode");
    chk_ais_pins: assert property (launch && mode_q.mode != pft_pkg::PFT_MODE_QUAD
        |=> transmit_tristate_ctl_n_o[1] == $past(mode_q.alt_input_sel_lo)
        && transmit_tristate_ctl_n_o[3] == $past(mode_q.alt_input_sel_hi))
        else $error("select bits not on tristate control pins");
    chk_rx_select: assert property (rx_edge && mode_q.mode == pft_pkg::PFT_MODE_SINGLE
        |=> rx_data_o[0] == $past(mode_q.alt_input_sel_hi ? pins_s[2] : pins_s[3]))
        else $error("single mode receive line wrong");
    chk_rx_edge: assert property (rx_stb_o |-> $past(shift_q.downstream_edge_sel ? rise : fall))
        else $error("receive capture on wrong clock edge");

    cov_sync_match: cover property (tick && sync_pend_q && cnt_q == last_bit);
    cov_free_wrap: cover property (tick && !sync_pend_q && cnt_q == last_bit);
    cov_dup_launch: cover property (launch && mode_q.mode == pft_pkg::PFT_MODE_DUP);
    cov_status_ok: cover property (sync_ok_q);

endmodule : pft_frame_timing

`default_nettype wire

// [testbench/pft_highway_model.sv]
// Far-end highway equipment: free-running bit clock, frame sync pulses, receive lines.
// Assumes the bench gives the sync period in bits (0 stops pulses) and the receive pattern.
`timescale 1ns/1ps
`default_nettype none

module pft_highway_model (
    // Bench control
    input wire logic [7:0] fs_period_i,
    input wire logic [3:0] rx_pat_i,
    // Highway pins
    output logic bclk_o,
    output logic fsync_o,
    output logic [3:0] rxd_o,
    // Line values present at each clock edge
    output logic [3:0] rx_rise_o,
    output logic [3:0] rx_fall_o
);
    int bits;

    initial begin
        bclk_o = 1'b0;
        fsync_o = 1'b0;
        rxd_o = 4'h0;
        rx_rise_o = 4'h0;
        rx_fall_o = 4'h0;
        bits = 0;
        #137;
        forever #400 bclk_o = ~bclk_o;
    end

    // Lines change mid half-period so they are stable at both edges
    always @(bclk_o) begin
        if (bclk_o) begin
            rx_rise_o = rxd_o;
        end else begin
            rx_fall_o = rxd_o;
        end
        rxd_o <= #200 rx_pat_i;
    end

    // One-bit pulse, low for every other bit of the period
    always @(posedge bclk_o) begin
        bits = (fs_period_i == 8'h00 || bits + 1 >= int'(fs_period_i)) ? 0 : bits + 1;
        if (fs_period_i != 8'h00 && bits == 0) begin
            fsync_o <= #200 1'b1;
        end else begin
            fsync_o <= #200 1'b0;
        end
    end
endmodule : pft_highway_model
`default_nettype wire

// [testbench/pft_frame_timing_tb.sv]
// Self-checking bench for the highway frame timing block.
// Assumes the far-end model pft_highway_model and a 10 MHz system clock.
`timescale 1ns/1ps
`default_nettype none

module pft_frame_timing_tb;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, bclk, fsync, tx_take_o, rx_stb_o;
    logic [7:0] wb_adr_i, fs_period;
    logic [3:0] wb_sel_i, tx_data_i, tx_valid_i, rxd, txd_o, txd_oe_o, tsc_n, rx_data_o, rx_rise, rx_fall;
    logic [31:0] wb_dat_i, wb_dat_o, rnd, rd;
    logic [9:0] up_pos_o, dn_pos_o, u0, d0, u1, d1;
    int miscompares, total_checks;
    logic [7:0] ofs [7] = '{pft_pkg::PFT_OFS_MODE, pft_pkg::PFT_OFS_LEN, pft_pkg::PFT_OFS_DOFF,
        pft_pkg::PFT_OFS_UOFF, pft_pkg::PFT_OFS_SHIFT, pft_pkg::PFT_OFS_STATUS, 8'h18};
    logic [7:0] rst_v [7] = '{pft_pkg::PFT_RST_MODE, pft_pkg::PFT_RST_LEN, pft_pkg::PFT_RST_DOFF,
        pft_pkg::PFT_RST_UOFF, pft_pkg::PFT_RST_SHIFT, 8'h00, 8'h00};

    pft_frame_timing DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .highway_bit_clock_i(bclk), .frame_sync_in_i(fsync),
        .rxd_i(rxd), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .transmit_tristate_ctl_n_o(tsc_n),
        .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_take_o(tx_take_o), .up_pos_o(up_pos_o),
        .rx_data_o(rx_data_o), .rx_stb_o(rx_stb_o), .dn_pos_o(dn_pos_o));

    pft_highway_model far_end (.fs_period_i(fs_period), .rx_pat_i(rnd[3:0]), .bclk_o(bclk),
        .fsync_o(fsync), .rxd_o(rxd), .rx_rise_o(rx_rise), .rx_fall_o(rx_fall));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) rnd <= lfsr(rnd);

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        check("bus answer", 32'd1, 32'(n < 20));
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic wait_ev(input logic rx);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((rx ? rx_stb_o : tx_take_o) !== 1'b1 && n < 100);
        if (n >= 100) miscompares++;
    endtask : wait_ev

    // Positions a fixed time after a frame sync pulse on the pin
    task automatic measure(output logic [9:0] up, output logic [9:0] dn);
        int n;
        n = 0;
        while (fsync === 1'b1 && n < 4000) begin
            @(posedge clk_i);
            n++;
        end
        while (fsync !== 1'b1 && n < 4000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 4000) miscompares++;
        repeat (4) wait_ev(1'b0);
        up = up_pos_o;
        wait_ev(1'b1);
        dn = dn_pos_o;
    endtask : measure

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    initial begin
        #5_000_000;
        miscompares++;
        end_sim();
    end

    initial begin
        logic [3:0] ec, ed, mk, raw, er, eo;
        logic [7:0] wv;
        logic hi, lo;
        clk_i = 1'b0;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {tx_data_i, tx_valid_i, fs_period} = '0;
        rnd = 32'h90116988;
        miscompares = 0;
        total_checks = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            wb(1'b0, ofs[i], 32'h0);
            check("reset value", {24'h0, rst_v[i]}, rd);
            wv = rnd[15:8];
            wb(1'b1, ofs[i], {24'h0, wv});
            wb(1'b0, ofs[i], 32'h0);
            if (i < 5) check("read back", {24'h0, wv}, rd);
            else check("read-only or unmapped", 32'h0, rd);
        end
        $display("test registers done");
        wb(1'b1, pft_pkg::PFT_OFS_LEN, 32'hff);
        for (int m = 0; m < 4; m++) begin
            for (int a = 0; a < 4; a++) begin
                {hi, lo} = (m == 0) ? 2'b00 : 2'(a);
                wb(1'b1, pft_pkg::PFT_OFS_MODE, {24'h0, 2'(m), 2'b00, hi, lo, 2'b00});
                wb(1'b1, pft_pkg::PFT_OFS_SHIFT, {27'h0, a[0], 3'b000, a[1]});
                tx_data_i <= rnd[3:0];
                tx_valid_i <= rnd[7:4];
                repeat (2) wait_ev(1'b0);
                ed = tx_data_i;
                ec = ~tx_valid_i;
                eo = tx_valid_i;
                mk = 4'hf;
                if (m != 0) begin
                    eo = (m == 3) ? {{2{tx_valid_i[1]}}, {2{tx_valid_i[0]}}} : {1'b0, tx_valid_i[1], 1'b0, tx_valid_i[0]};
                    ed = (m == 3) ? {{2{tx_data_i[1]}}, {2{tx_data_i[0]}}} : {1'b0, tx_data_i[1], 1'b0, tx_data_i[0]};
                    mk = (m == 3) ? 4'hf : 4'h5;
                    ec = {hi, ~tx_valid_i[1], lo, ~tx_valid_i[0]};
                end
                if (m == 2) begin
                    mk = 4'h1;
                    ec[2] = 1'b1;
                end
                check("txd", {28'h0, ed & mk}, {28'h0, txd_o & mk});
                check("txd_oe floating", 32'h0, {28'h0, txd_oe_o & ~mk});
                check("txd_oe driven", {28'h0, eo & mk}, {28'h0, txd_oe_o & mk});
                check("tristate ctl", {28'h0, ec}, {28'h0, tsc_n});
                repeat (2) wait_ev(1'b1);
                raw = a[0] ? rx_rise : rx_fall;
                er = (m == 0) ? raw : (m == 2) ? {3'b0, hi ? raw[2] : raw[3]}
                    : {2'b0, hi ? raw[2] : raw[3], lo ? raw[0] : raw[1]};
                mk = (m == 0) ? 4'hf : (m == 2) ? 4'h1 : 4'h3;
                check("rx_data", {28'h0, er}, {28'h0, rx_data_o & mk});
            end
        end
        $display("test line mapping done");
        wb(1'b1, pft_pkg::PFT_OFS_MODE, 32'h0);
        // Offsets left random by the register test would exceed the short frame
        wb(1'b1, pft_pkg::PFT_OFS_DOFF, 32'h0);
        wb(1'b1, pft_pkg::PFT_OFS_UOFF, 32'h0);
        wb(1'b1, pft_pkg::PFT_OFS_LEN, 32'd31);
        wb(1'b1, pft_pkg::PFT_OFS_SHIFT, 32'h01);
        fs_period <= 8'd32;
        measure(u0, d0);
        measure(u0, d0);
        measure(u1, d1);
        check("up_pos after sync", 32'(u0), 32'(u1));
        check("dn_pos after sync", 32'(d0), 32'(d1));
        wb(1'b0, pft_pkg::PFT_OFS_STATUS, 32'h0);
        check("sync status", 32'h1, rd);
        wb(1'b1, pft_pkg::PFT_OFS_UOFF, 32'h1);
        measure(u1, d1);
        measure(u1, d1);
        check("up_pos offset", (32'(u0) + 32'd4) % 32'd32, 32'(u1));
        check("dn_pos kept", 32'(d0), 32'(d1));
        wb(1'b1, pft_pkg::PFT_OFS_DOFF, 32'h2);
        measure(u1, d1);
        measure(u1, d1);
        check("dn_pos offset", (32'(d0) + 32'd8) % 32'd32, 32'(d1));
        check("up_pos kept", (32'(u0) + 32'd4) % 32'd32, 32'(u1));
        wb(1'b1, pft_pkg::PFT_OFS_UOFF, 32'h0);
        wb(1'b1, pft_pkg::PFT_OFS_MODE, 32'h10);
        measure(u1, d1);
        measure(u1, d1);
        check("rising edge sync", (32'(u0) + 32'd31) % 32'd32, 32'(u1));
        $display("test frame sync done");
        fs_period <= 8'd40;
        repeat (1500) @(posedge clk_i);
        wb(1'b0, pft_pkg::PFT_OFS_STATUS, 32'h0);
        check("sync status wrong period", 32'h0, rd);
        fs_period <= 8'd0;
        repeat (600) @(posedge clk_i);
        wait_ev(1'b0);
        u1 = up_pos_o;
        repeat (32) wait_ev(1'b0);
        check("free-run wrap", 32'(u1), 32'(up_pos_o));
        check("position in frame", 32'h1, 32'(up_pos_o < 10'd32));
        // Double clock rate: two rising edges per bit, so 32 launches move 16 bits
        wb(1'b1, pft_pkg::PFT_OFS_MODE, 32'h20);
        wait_ev(1'b0);
        u1 = up_pos_o;
        repeat (32) wait_ev(1'b0);
        check("double rate position", (32'(u1) + 32'd16) % 32'd32, 32'(up_pos_o));
        $display("test free run done");
        end_sim();
    end
endmodule : pft_frame_timing_tb
`default_nettype wire
